// file: pkg/pdc_pkg.sv
// package: register map, fields, resets and carrier structs of the power-down config block
package pdc_pkg;
    // page selects
    localparam logic [7:0]  PAGE_MASTER     = 8'h80;
    localparam logic [7:0]  PAGE_ADC        = 8'h0F;
    localparam logic [15:0] PAGE_MAIN_DIG   = 16'h6800;
    // offsets (register address low bits)
    localparam logic [11:0] OFS_ANA_PAGE    = 12'h011;
    localparam logic [11:0] OFS_JESD_PG_LO  = 12'h003;
    localparam logic [11:0] OFS_JESD_PG_HI  = 12'h004;
    localparam logic [11:0] OFS_MASK1_CONV  = 12'h020;
    localparam logic [11:0] OFS_MASK1_BUF   = 12'h021;
    localparam logic [11:0] OFS_MASK2_CONV  = 12'h023;
    localparam logic [11:0] OFS_MASK2_BUF   = 12'h024;
    localparam logic [11:0] OFS_GLOBAL_PWR  = 12'h026;
    localparam logic [11:0] OFS_IN_COUPLE   = 12'h04F;
    localparam logic [11:0] OFS_SREF_CTRL   = 12'h053;
    localparam logic [11:0] OFS_REG_PWR_EN  = 12'h055;
    localparam logic [11:0] OFS_OVR_ROUTE   = 12'h059;
    localparam logic [11:0] OFS_OVR_THRESH  = 12'h05F;
    localparam logic [11:0] OFS_APPLY_RST   = 12'h000;
    // address bit 14 selects the jesd bank
    localparam int          JESD_BANK_BIT   = 14;
    // field positions
    localparam int          BIT_WHOLE_SLEEP = 7;
    localparam int          BIT_PIN_OVR     = 6;
    localparam int          BIT_SET_CHOICE  = 5;
    localparam int          BIT_REG_SLEEP   = 4;
    localparam int          BIT_IGN_SREF    = 6;
    localparam int          BIT_SREF_HICM   = 1;
    localparam int          BIT_IN_DC       = 0;
    localparam int          BIT_ROUTE_OVR   = 7;
    localparam int          BIT_ROUTE_EN    = 5;
    localparam int          BIT_APPLY       = 0;
    // writable-bit masks, reserved positions are dropped
    localparam logic [7:0]  WMASK_CONV      = 8'hFF;
    localparam logic [7:0]  WMASK_BUF       = 8'hF0;
    localparam logic [7:0]  WMASK_GLOBAL    = 8'hE0;
    localparam logic [7:0]  WMASK_IN_DC     = 8'h01;
    localparam logic [7:0]  WMASK_SREF      = 8'h42;
    localparam logic [7:0]  WMASK_REG_PWR   = 8'h10;
    localparam logic [7:0]  WMASK_ROUTE     = 8'hA0;
    // reset values
    localparam logic [7:0]  RST_ZERO        = 8'h00;
    localparam logic [7:0]  RST_THRESH      = 8'hE3;

    typedef struct packed {
        logic [7:0] conv;
        logic [7:0] buf_;
    } pdc_mask_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } pdc_req_s;
endpackage

// file: hw/pdc_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pdc_sync2 (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_d,
    output logic      o_q
);
    logic meta_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= 1'b0;
            o_q    <= 1'b0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule

// file: hw/pdc_shadow.sv
// shadow register: pending value copied to active on apply pulse
`timescale 1ns/1ps
module pdc_shadow #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_wr,
    input  wire logic [W-1:0] i_wdata,
    input  wire logic         i_apply,
    output logic      [W-1:0] o_pending,
    output logic      [W-1:0] o_active
);
    initial begin
        if (W < 1) $error("pdc_shadow: W must be positive");
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) o_pending <= '0;
        else if (i_wr) o_pending <= i_wdata;
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) o_active <= '0;
        else if (i_apply) o_active <= o_pending;
    end
endmodule

// file: hw/pdc_top.sv
// power-down, sysref, coupling, overrange and apply-reset configuration registers
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pdc_top #(
    parameter int MAIN_W = 8
) (
    input  wire logic              I_MCLK,
    input  wire logic              I_SYS_RST,
    input  wire pdc_pkg::pdc_req_s I_REQ,
    input  wire logic [MAIN_W-1:0] I_MAIN_WDATA,
    input  wire logic              I_MAIN_WR,
    input  wire logic              I_SLEEP_PIN,
    input  wire logic              I_SYSREF,
    input  wire logic              I_OVR_CHB,
    input  wire logic              I_READBACK_BIT,
    output logic [7:0]             O_RDATA,
    output logic                   O_RVALID,
    output logic [7:0]             O_CONV_OFF,
    output logic [7:0]             O_BUF_OFF,
    output logic                   O_WHOLE_SLEEP,
    output logic                   O_SYSREF_EVT,
    output logic                   O_INPUT_DC_BIAS,
    output logic                   O_SYSREF_HICM,
    output logic [7:0]             O_OVERRANGE_LEVEL,
    output logic                   O_SERIAL_READBACK_OUT,
    output logic [MAIN_W-1:0]      O_MAIN_ACTIVE,
    output logic                   O_APPLY_PULSE
);
    initial begin
        if (MAIN_W < 1) $error("pdc_top: MAIN_W must be positive");
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]  ana_page_q;
    logic [15:0] jesd_page_q;
    logic [7:0]  m1_conv_q, m1_buf_q, m2_conv_q, m2_buf_q;
    logic [7:0]  global_q, in_dc_q, sref_q, reg_pwr_q, route_q, thresh_q;
    logic        apply_bit_q;
    logic        apply_pulse;
    logic        pin_s, sref_s, ovr_s, rb_s;
    logic        sref_s_q;
    logic        jesd_acc, master_acc, adc_acc, main_acc;
    logic [11:0] ofs;
    logic        wr, rd;
    logic [7:0]  wd;
    logic [7:0]  rdata_d;
    pdc_pkg::pdc_mask_s sel_mask;
    logic [MAIN_W-1:0]  main_pending;

    assign ofs        = I_REQ.addr[11:0];
    assign wr         = I_REQ.wr;
    assign rd         = I_REQ.rd;
    assign wd         = I_REQ.wdata;
    assign jesd_acc   = I_REQ.addr[pdc_pkg::JESD_BANK_BIT];
    assign master_acc = !jesd_acc && ana_page_q == pdc_pkg::PAGE_MASTER;
    assign adc_acc    = !jesd_acc && ana_page_q == pdc_pkg::PAGE_ADC;
    assign main_acc   = jesd_acc && jesd_page_q == pdc_pkg::PAGE_MAIN_DIG;

    ////////////////////////////////////////////////////////////////////////////
    // pin inputs
    pdc_sync2 u_sync_pin (.i_clk(I_MCLK), .i_rst(I_SYS_RST), .i_d(I_SLEEP_PIN),
                          .o_q(pin_s));
    pdc_sync2 u_sync_sref (.i_clk(I_MCLK), .i_rst(I_SYS_RST), .i_d(I_SYSREF),
                           .o_q(sref_s));
    pdc_sync2 u_sync_ovr (.i_clk(I_MCLK), .i_rst(I_SYS_RST), .i_d(I_OVR_CHB),
                          .o_q(ovr_s));
    pdc_sync2 u_sync_rb (.i_clk(I_MCLK), .i_rst(I_SYS_RST), .i_d(I_READBACK_BIT),
                         .o_q(rb_s));

    ////////////////////////////////////////////////////////////////////////////
    // page selects
    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            ana_page_q <= pdc_pkg::RST_ZERO;
        end else if (wr && !jesd_acc && ofs == pdc_pkg::OFS_ANA_PAGE) begin
            ana_page_q <= wd;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            jesd_page_q <= 16'h0000;
        end else if (wr && !jesd_acc && ofs == pdc_pkg::OFS_JESD_PG_LO) begin
            jesd_page_q[7:0] <= wd;
        end else if (wr && !jesd_acc && ofs == pdc_pkg::OFS_JESD_PG_HI) begin
            jesd_page_q[15:8] <= wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // master and adc page registers, reserved bits masked off
    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            m1_conv_q <= pdc_pkg::RST_ZERO;
            m1_buf_q  <= pdc_pkg::RST_ZERO;
            m2_conv_q <= pdc_pkg::RST_ZERO;
            m2_buf_q  <= pdc_pkg::RST_ZERO;
            global_q  <= pdc_pkg::RST_ZERO;
            in_dc_q   <= pdc_pkg::RST_ZERO;
            sref_q    <= pdc_pkg::RST_ZERO;
            reg_pwr_q <= pdc_pkg::RST_ZERO;
            route_q   <= pdc_pkg::RST_ZERO;
        end else if (wr && master_acc) begin
            case (ofs)
                pdc_pkg::OFS_MASK1_CONV: m1_conv_q <= wd & pdc_pkg::WMASK_CONV;
                pdc_pkg::OFS_MASK1_BUF:  m1_buf_q  <= wd & pdc_pkg::WMASK_BUF;
                pdc_pkg::OFS_MASK2_CONV: m2_conv_q <= wd & pdc_pkg::WMASK_CONV;
                pdc_pkg::OFS_MASK2_BUF:  m2_buf_q  <= wd & pdc_pkg::WMASK_BUF;
                pdc_pkg::OFS_GLOBAL_PWR: begin
                    global_q <= wd & pdc_pkg::WMASK_GLOBAL;
                    // sleep bit only kept while override stands before and after the write
                    if (!global_q[pdc_pkg::BIT_PIN_OVR] || !wd[pdc_pkg::BIT_PIN_OVR]) begin
                        global_q[pdc_pkg::BIT_WHOLE_SLEEP] <= 1'b0;
                    end
                end
                pdc_pkg::OFS_IN_COUPLE:  in_dc_q   <= wd & pdc_pkg::WMASK_IN_DC;
                pdc_pkg::OFS_SREF_CTRL:  sref_q    <= wd & pdc_pkg::WMASK_SREF;
                pdc_pkg::OFS_REG_PWR_EN: reg_pwr_q <= wd & pdc_pkg::WMASK_REG_PWR;
                pdc_pkg::OFS_OVR_ROUTE:  route_q   <= wd & pdc_pkg::WMASK_ROUTE;
                default: ;
            endcase
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            thresh_q <= pdc_pkg::RST_THRESH;
        end else if (wr && adc_acc && ofs == pdc_pkg::OFS_OVR_THRESH) begin
            thresh_q <= wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apply-reset bit and falling-edge pulse
    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            apply_bit_q <= 1'b0;
        end else if (wr && main_acc && ofs == pdc_pkg::OFS_APPLY_RST) begin
            apply_bit_q <= wd[pdc_pkg::BIT_APPLY];
        end
    end

    assign apply_pulse = apply_bit_q && wr && main_acc && ofs == pdc_pkg::OFS_APPLY_RST
                         && !wd[pdc_pkg::BIT_APPLY];

    pdc_shadow #(.W(MAIN_W)) u_main (
        .i_clk    (I_MCLK),
        .i_rst    (I_SYS_RST),
        .i_wr     (I_MAIN_WR),
        .i_wdata  (I_MAIN_WDATA),
        .i_apply  (apply_pulse),
        .o_pending(main_pending),
        .o_active (O_MAIN_ACTIVE)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read path
    always_comb begin
        rdata_d = 8'h00;
        if (!jesd_acc && ofs == pdc_pkg::OFS_ANA_PAGE) rdata_d = ana_page_q;
        else if (!jesd_acc && ofs == pdc_pkg::OFS_JESD_PG_LO) rdata_d = jesd_page_q[7:0];
        else if (!jesd_acc && ofs == pdc_pkg::OFS_JESD_PG_HI) rdata_d = jesd_page_q[15:8];
        else if (master_acc) begin
            case (ofs)
                pdc_pkg::OFS_MASK1_CONV: rdata_d = m1_conv_q;
                pdc_pkg::OFS_MASK1_BUF:  rdata_d = m1_buf_q;
                pdc_pkg::OFS_MASK2_CONV: rdata_d = m2_conv_q;
                pdc_pkg::OFS_MASK2_BUF:  rdata_d = m2_buf_q;
                pdc_pkg::OFS_GLOBAL_PWR: rdata_d = global_q;
                pdc_pkg::OFS_IN_COUPLE:  rdata_d = in_dc_q;
                pdc_pkg::OFS_SREF_CTRL:  rdata_d = sref_q;
                pdc_pkg::OFS_REG_PWR_EN: rdata_d = reg_pwr_q;
                pdc_pkg::OFS_OVR_ROUTE:  rdata_d = route_q;
                default:                 rdata_d = 8'h00;
            endcase
        end else if (adc_acc && ofs == pdc_pkg::OFS_OVR_THRESH) rdata_d = thresh_q;
        else if (main_acc && ofs == pdc_pkg::OFS_APPLY_RST) begin
            rdata_d = {7'h00, apply_bit_q};
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            O_RDATA  <= 8'h00;
            O_RVALID <= 1'b0;
        end else begin
            O_RVALID <= rd;
            if (rd) O_RDATA <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-down outputs
    always_comb begin
        if (global_q[pdc_pkg::BIT_SET_CHOICE]) begin
            sel_mask = '{conv: m2_conv_q, buf_: m2_buf_q};
        end else begin
            sel_mask = '{conv: m1_conv_q, buf_: m1_buf_q};
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            O_CONV_OFF    <= 8'h00;
            O_BUF_OFF     <= 8'h00;
            O_WHOLE_SLEEP <= 1'b0;
        end else begin
            O_CONV_OFF <= reg_pwr_q[pdc_pkg::BIT_REG_SLEEP] ? sel_mask.conv : 8'h00;
            O_BUF_OFF  <= reg_pwr_q[pdc_pkg::BIT_REG_SLEEP] ? sel_mask.buf_ : 8'h00;
            if (global_q[pdc_pkg::BIT_PIN_OVR]) begin
                O_WHOLE_SLEEP <= global_q[pdc_pkg::BIT_WHOLE_SLEEP];
            end else begin
                O_WHOLE_SLEEP <= pin_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sysref, coupling, overrange
    always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
            sref_s_q         <= 1'b0;
            O_SYSREF_EVT     <= 1'b0;
            O_INPUT_DC_BIAS  <= 1'b0;
            O_SYSREF_HICM    <= 1'b0;
            O_OVERRANGE_LEVEL <= pdc_pkg::RST_THRESH;
            O_SERIAL_READBACK_OUT <= 1'b0;
            O_APPLY_PULSE    <= 1'b0;
        end else begin
            sref_s_q        <= sref_s;
            O_SYSREF_EVT    <= sref_s && !sref_s_q && !sref_q[pdc_pkg::BIT_IGN_SREF];
            O_INPUT_DC_BIAS <= in_dc_q[pdc_pkg::BIT_IN_DC];
            O_SYSREF_HICM   <= sref_q[pdc_pkg::BIT_SREF_HICM];
            O_OVERRANGE_LEVEL <= thresh_q;
            // routing needs the enable bit kept high by software
            if (route_q[pdc_pkg::BIT_ROUTE_OVR] && route_q[pdc_pkg::BIT_ROUTE_EN]) begin
                O_SERIAL_READBACK_OUT <= ovr_s;
            end else begin
                O_SERIAL_READBACK_OUT <= rb_s;
            end
            O_APPLY_PULSE <= apply_pulse;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    sequence s_apply_fall;
        wr && main_acc && ofs == pdc_pkg::OFS_APPLY_RST && !wd[0] && apply_bit_q;
    endsequence

    a_mask_sel_two: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        reg_pwr_q[4] && global_q[5] |=> O_CONV_OFF == $past(m2_conv_q))
        else $error("mask two not applied");
    a_mask_sel_one: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        reg_pwr_q[4] && !global_q[5] |=> O_BUF_OFF == $past(m1_buf_q))
        else $error("mask one not applied");
    a_mask_two_buf: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        reg_pwr_q[4] && global_q[5] |=> O_BUF_OFF == $past(m2_buf_q))
        else $error("mask two buffers not applied");
    a_mask_off_idle: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        !reg_pwr_q[4] |=> O_CONV_OFF == 8'h00 && O_BUF_OFF == 8'h00)
        else $error("power-down without enable");
    a_sleep_interlock: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        !global_q[6] |=> !global_q[7])
        else $error("sleep bit set without override");
    a_pin_follows: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        !global_q[6] ##1 !global_q[6] |=> O_WHOLE_SLEEP == $past(pin_s))
        else $error("sleep pin not followed");
    a_sysref_mask: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        sref_q[6] |=> !O_SYSREF_EVT)
        else $error("sysref passed while ignored");
    a_ovr_route: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        route_q[7] && route_q[5] |=> O_SERIAL_READBACK_OUT == $past(ovr_s))
        else $error("overrange not routed");
    a_thresh_out: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        1'b1 |=> O_OVERRANGE_LEVEL == $past(thresh_q))
        else $error("threshold output mismatch");
    a_apply_copy: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        !apply_pulse |=> $stable(O_MAIN_ACTIVE))
        else $error("main settings changed without apply");
    a_apply_pulse: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        s_apply_fall |=> O_APPLY_PULSE ##1 !O_APPLY_PULSE)
        else $error("apply pulse not single");
    a_coupling_out: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
        1'b1 |=> O_INPUT_DC_BIAS == $past(in_dc_q[0]) && O_SYSREF_HICM == $past(sref_q[1]))
        else $error("coupling outputs mismatch");
endmodule

// file: tb/pdc_host.sv
// host model driving the configuration request port of the power-down block
`timescale 1ns/1ps
module pdc_host (
    input  wire logic        i_clk,
    input  wire logic [7:0]  i_rdata,
    input  wire logic        i_rvalid,
    output pdc_pkg::pdc_req_s o_req
);
    initial o_req = '0;

    // one request per call, released address and data show inverted values
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        int i;
        @(posedge i_clk);
        o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk);
        o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
        d = 8'hXX;
        for (i = 0; i < 4; i++) begin
            #1;
            if (i_rvalid === 1'b1) begin
                d = i_rdata;
                break;
            end
            @(posedge i_clk);
        end
    endtask

    // page selects come before any access to the paged registers
    task automatic sel_analog(input logic [7:0] pg);
        wr({4'h0, pdc_pkg::OFS_ANA_PAGE}, pg);
    endtask

    task automatic sel_main_digital();
        // page select registers sit in the analog bank, bank bit clear
        wr({4'h0, pdc_pkg::OFS_JESD_PG_LO}, pdc_pkg::PAGE_MAIN_DIG[7:0]);
        wr({4'h0, pdc_pkg::OFS_JESD_PG_HI}, pdc_pkg::PAGE_MAIN_DIG[15:8]);
    endtask

    // apply bit is written 1 then 0, reserved bits always 0
    task automatic pulse_apply();
        wr({4'h4, pdc_pkg::OFS_APPLY_RST}, 8'h01);
        wr({4'h4, pdc_pkg::OFS_APPLY_RST}, 8'h00);
    endtask
endmodule

// file: tb/pdc_top_tb.sv
// self-checking testbench of the power-down configuration registers
`timescale 1ns/1ps
module pdc_top_tb;
    logic              i_mclk;
    logic              i_sys_rst;
    pdc_pkg::pdc_req_s req;
    logic [7:0]        main_wdata;
    logic              main_wr;
    logic              sleep_pin;
    logic              sysref;
    logic              ovr_chb;
    logic              rb_bit;
    logic [7:0]        rdata;
    logic              rvalid;
    logic [7:0]        conv_off;
    logic [7:0]        buf_off;
    logic              whole_sleep;
    logic              sysref_evt;
    logic              in_dc;
    logic              sref_hicm;
    logic [7:0]        ovr_level;
    logic              rb_out;
    logic [7:0]        main_active;
    logic              apply_pulse;
    int                fail_count;
    int                check_count;
    int                evt_n;
    int                apply_n;
    logic [7:0]        d;
    logic [11:0]       ofs [8];
    logic [7:0]        msk [8];

    pdc_top #(.MAIN_W(8)) pdc_top_i (
        .I_MCLK(i_mclk), .I_SYS_RST(i_sys_rst), .I_REQ(req), .I_MAIN_WDATA(main_wdata),
        .I_MAIN_WR(main_wr), .I_SLEEP_PIN(sleep_pin), .I_SYSREF(sysref),
        .I_OVR_CHB(ovr_chb), .I_READBACK_BIT(rb_bit), .O_RDATA(rdata), .O_RVALID(rvalid),
        .O_CONV_OFF(conv_off), .O_BUF_OFF(buf_off), .O_WHOLE_SLEEP(whole_sleep),
        .O_SYSREF_EVT(sysref_evt), .O_INPUT_DC_BIAS(in_dc), .O_SYSREF_HICM(sref_hicm),
        .O_OVERRANGE_LEVEL(ovr_level), .O_SERIAL_READBACK_OUT(rb_out),
        .O_MAIN_ACTIVE(main_active), .O_APPLY_PULSE(apply_pulse));

    pdc_host pdc_host_i (.i_clk(i_mclk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk) begin
        if (sysref_evt === 1'b1) evt_n++;
        if (apply_pulse === 1'b1) apply_n++;
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask

    task automatic rchk(input logic [11:0] o, input logic [7:0] e);
        pdc_host_i.rd({4'h0, o}, d);
        chk("readback", {8'h00, e}, {8'h00, d});
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_mclk);
        fail_count++;
        give_verdict();
    end

    initial begin
        i_sys_rst = 1'b1;
        main_wdata = 8'h00;
        main_wr = 1'b0;
        sleep_pin = 1'b0;
        sysref = 1'b0;
        ovr_chb = 1'b0;
        rb_bit = 1'b0;
        ofs = '{pdc_pkg::OFS_MASK1_CONV, pdc_pkg::OFS_MASK1_BUF, pdc_pkg::OFS_MASK2_CONV,
                pdc_pkg::OFS_MASK2_BUF, pdc_pkg::OFS_IN_COUPLE, pdc_pkg::OFS_SREF_CTRL,
                pdc_pkg::OFS_REG_PWR_EN, pdc_pkg::OFS_OVR_ROUTE};
        msk = '{pdc_pkg::WMASK_CONV, pdc_pkg::WMASK_BUF, pdc_pkg::WMASK_CONV,
                pdc_pkg::WMASK_BUF, pdc_pkg::WMASK_IN_DC, pdc_pkg::WMASK_SREF,
                pdc_pkg::WMASK_REG_PWR, pdc_pkg::WMASK_ROUTE};
        repeat (4) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        #1;
        chk("threshold out", 16'h00E3, {8'h00, ovr_level});
        pdc_host_i.sel_analog(pdc_pkg::PAGE_MASTER);
        ////////////////////////////////////////////////////////////////////////
        // reset values and reserved bits
        for (int i = 0; i < 8; i++) begin
            rchk(ofs[i], 8'h00);
            pdc_host_i.wr({4'h0, ofs[i]}, 8'hFF);
            rchk(ofs[i], msk[i]);
            pdc_host_i.wr({4'h0, ofs[i]}, 8'h00);
        end
        rchk(12'h030, 8'h00);
        ////////////////////////////////////////////////////////////////////////
        // mask selection
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_MASK1_CONV}, 8'h12);
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_MASK1_BUF}, 8'h40);
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_MASK2_CONV}, 8'h34);
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_MASK2_BUF}, 8'h80);
        wait_n(2);
        chk("conv off idle", 16'h0000, {8'h00, conv_off});
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_REG_PWR_EN}, 8'h10);
        wait_n(2);
        chk("conv mask one", 16'h0012, {8'h00, conv_off});
        chk("buf mask one", 16'h0040, {8'h00, buf_off});
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_GLOBAL_PWR}, 8'h20);
        wait_n(2);
        chk("conv mask two", 16'h0034, {8'h00, conv_off});
        chk("buf mask two", 16'h0080, {8'h00, buf_off});
        ////////////////////////////////////////////////////////////////////////
        // global sleep, override interlock and sleep pin
        sleep_pin <= 1'b1;
        wait_n(5);
        chk("pin sleep", 16'h0001, {15'h0, whole_sleep});
        sleep_pin <= 1'b0;
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_GLOBAL_PWR}, 8'h80);
        wait_n(5);
        rchk(pdc_pkg::OFS_GLOBAL_PWR, 8'h00);
        chk("global no override", 16'h0000, {15'h0, whole_sleep});
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_GLOBAL_PWR}, 8'h40);
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_GLOBAL_PWR}, 8'hC0);
        wait_n(2);
        chk("global sleep", 16'h0001, {15'h0, whole_sleep});
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_GLOBAL_PWR}, 8'h80);
        rchk(pdc_pkg::OFS_GLOBAL_PWR, 8'h00);
        sleep_pin <= 1'b1;
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_GLOBAL_PWR}, 8'h40);
        wait_n(5);
        chk("pin ignored", 16'h0000, {15'h0, whole_sleep});
        sleep_pin <= 1'b0;
        ////////////////////////////////////////////////////////////////////////
        // sysref events, coupling levels
        for (int m = 0; m < 2; m++) begin
            pdc_host_i.wr({4'h0, pdc_pkg::OFS_SREF_CTRL}, (m == 1) ? 8'h40 : 8'h02);
            evt_n = 0;
            sysref <= 1'b1;
            wait_n(4);
            sysref <= 1'b0;
            wait_n(4);
            chk("sysref events", (m == 1) ? 16'h0 : 16'h1, 16'(evt_n));
        end
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_SREF_CTRL}, 8'h02);
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_IN_COUPLE}, 8'h01);
        wait_n(2);
        chk("input dc bias", 16'h0001, {15'h0, in_dc});
        chk("sysref hicm", 16'h0001, {15'h0, sref_hicm});
        ////////////////////////////////////////////////////////////////////////
        // overrange routing on the readback pin
        rb_bit <= 1'b1;
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_OVR_ROUTE}, 8'h20);
        wait_n(5);
        chk("readback normal", 16'h0001, {15'h0, rb_out});
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_OVR_ROUTE}, 8'hA0);
        wait_n(5);
        chk("route ovr low", 16'h0000, {15'h0, rb_out});
        ovr_chb <= 1'b1;
        rb_bit <= 1'b0;
        wait_n(5);
        chk("route ovr high", 16'h0001, {15'h0, rb_out});
        ////////////////////////////////////////////////////////////////////////
        // threshold on the adc page
        pdc_host_i.sel_analog(pdc_pkg::PAGE_ADC);
        rchk(pdc_pkg::OFS_OVR_THRESH, 8'hE3);
        pdc_host_i.wr({4'h0, pdc_pkg::OFS_OVR_THRESH}, 8'h5A);
        rchk(pdc_pkg::OFS_OVR_THRESH, 8'h5A);
        chk("threshold out", 16'h005A, {8'h00, ovr_level});
        ////////////////////////////////////////////////////////////////////////
        // pending main settings take effect on the apply pulse
        @(posedge i_mclk);
        main_wdata <= 8'hA5;
        main_wr <= 1'b1;
        @(posedge i_mclk);
        main_wr <= 1'b0;
        pdc_host_i.sel_main_digital();
        apply_n = 0;
        pdc_host_i.wr({4'h4, pdc_pkg::OFS_APPLY_RST}, 8'h01);
        wait_n(3);
        chk("active before", 16'h0000, {8'h00, main_active});
        chk("no early pulse", 16'h0000, 16'(apply_n));
        pdc_host_i.wr({4'h4, pdc_pkg::OFS_APPLY_RST}, 8'h00);
        wait_n(4);
        chk("apply pulses", 16'h0001, 16'(apply_n));
        chk("active after", 16'h00A5, {8'h00, main_active});
        pdc_host_i.pulse_apply();
        wait_n(4);
        chk("second apply", 16'h0002, 16'(apply_n));
        give_verdict();
    end
endmodule
